/* fspc_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the self-programming control block and its package
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH

// control register offset on the plain register port
`define FSPC_CTRL_OFS 4'h0
`define FSPC_CTRL_RST 8'h00
// fields of the control register
`define FSPC_BIT_IE 7
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_RSVD 5
`define FSPC_BIT_REEN 4
`define FSPC_BIT_LOCK 3
`define FSPC_BIT_PGWR 2
`define FSPC_BIT_PGER 1
`define FSPC_BIT_EN 0
// legal lower-five-bit command patterns
`define FSPC_CMD_REEN 5'h11
`define FSPC_CMD_LOCK 5'h09
`define FSPC_CMD_PGWR 5'h05
`define FSPC_CMD_PGER 5'h03
`define FSPC_CMD_FILL 5'h01
// window lengths in clock cycles
`define FSPC_STORE_WIN 3'h4
`define FSPC_LOAD_WIN 3'h3
// address split: word in page, then page select
`define FSPC_WORD_BITS 5
`define FSPC_PAGE_BITS 7
`define FSPC_PAGE_WORDS 32
// lowest page of the no-concurrent-read section
`define FSPC_NO_CONCURRENT_READ_SECTION_PAGE 7'h60
// application reset vector and boot loader start word address
`define FSPC_APP_VEC 12'h000
`define FSPC_BOOT_VEC 12'hC00

`endif

/* fspc_pkg.sv */
// types shared by the self-programming control block
// assumes fspc_regs.svh supplies all numeric constants
`include "fspc_regs.svh"
package fspc_pkg;

  typedef enum logic [1:0] {
    FSPC_IDLE = 2'b00,
    FSPC_ARMED = 2'b01,
    FSPC_BUSY = 2'b10
  } fspc_state_t;

  // request to the flash array, latched at operation start
  typedef struct packed {
    logic erase;
    logic write;
    logic lock;
    logic [`FSPC_PAGE_BITS-1:0] page;
    logic [7:0] lock_data;
  } fspc_op_t;

endpackage

/* fspc_ctrl.sv */
// self-programming control: control register, command windows,
// page buffer, section busy tracking, cpu halt and ready interrupt
// assumes the core pulses store/load strobes and the array acks done
//
// Overview of operation
// R1 - boot fuse selects application or boot vector
// R2 - processor has no path to alter fuses
// R3 - ready irq while enable, global flag, no program_enable
// R4 - rww erase/write sets busy, blocks section
// R5 - busy clears on reenable or page load
// R6 - reenable plus enable then store reopens section
// R7 - reenable refused while erase/write in progress
// R8 - reenable during buffer load discards loaded data
// R9 - lock_set store programs lock bits from low data
// R10 - load within three cycles reads lock or fuse
// R11 - page write stores buffer to pointer page
// R12 - page erase erases pointer page, data ignored
// R13 - cpu halted during no-concurrent-read page operation
// R14 - plain enable stores data pair into buffer
// R15 - program_enable four-cycle window, held during operation
// R16 - other lower-five-bit patterns have no effect
// R17 - bit five reads zero, read only
// R18 - target address latched at operation start
// R19 - low address bits word, high bits page
// R20 - software erases a page before writing it
// R21 - software uses same page for erase and write
// R22 - buffer words writable in any order
// R23 - buffer cleared after write, reenable, reset
// R24 - eeprom write blocks programming and readback
// R25 - command writes ignored while operation runs
`timescale 1ns/1ps
`include "fspc_regs.svh"

module fspc_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core side
  input wire logic store_program_instruction,
  input wire logic load_program_instruction,
  input wire logic [15:0] pointer,
  input wire logic [7:0] low_data_register,
  input wire logic [7:0] high_data_register,
  input wire logic global_irq_flag,
  input wire logic eeprom_write_busy,
  input wire logic boot_reset_fuse,
  output logic [11:0] reset_vector,
  output logic [7:0] load_result,
  output logic load_result_valid,
  output logic cpu_halt,
  output logic rww_blocked,
  output logic ready_irq,
  // flash array side
  input wire logic [7:0] lock_bits_in,
  input wire logic [7:0] fuse_low_in,
  input wire logic [7:0] fuse_high_in,
  input wire logic flash_done,
  output fspc_pkg::fspc_op_t flash_op,
  output logic flash_start,
  output logic [15:0] flash_wdata [`FSPC_PAGE_WORDS]
);

  // ****************************************************************
  // decode
  // ****************************************************************
  fspc_pkg::fspc_state_t state_reg, state_next;
  logic [4:0] cmd_reg;
  logic ie_reg;
  logic busy_reg;
  logic [2:0] win_reg;
  logic [2:0] ld_win_reg;
  logic [`FSPC_WORD_BITS-1:0] word_sel;
  logic [`FSPC_PAGE_BITS-1:0] page_sel;
  logic ctrl_wr;
  logic legal_cmd;
  logic armed;
  logic busy_op;
  logic do_store;
  logic do_load;
  logic win_lapse;
  logic op_start;
  logic fill_go;
  logic reen_go;
  logic op_rww;
  logic [7:0] ctrl_view;
  logic [7:0] readback;

  function automatic logic is_legal(input logic [4:0] c);
    is_legal = (c == `FSPC_CMD_REEN) || (c == `FSPC_CMD_LOCK) ||
      (c == `FSPC_CMD_PGWR) || (c == `FSPC_CMD_PGER) ||
      (c == `FSPC_CMD_FILL);
  endfunction

  assign ctrl_wr = reg_wr && (reg_addr == `FSPC_CTRL_OFS);
  assign legal_cmd = is_legal(reg_wdata[4:0]); // see R16
  assign armed = (state_reg == fspc_pkg::FSPC_ARMED);
  assign busy_op = (state_reg == fspc_pkg::FSPC_BUSY);
  // eeprom write blocks every store and readback
  assign do_store = armed && store_program_instruction &&
    !eeprom_write_busy; // see R24
  assign do_load = armed && load_program_instruction &&
    (cmd_reg == `FSPC_CMD_LOCK) && (ld_win_reg != 3'h0) &&
    !eeprom_write_busy; // see R10 and R24
  assign win_lapse = armed && !do_store && !do_load &&
    (win_reg == 3'h1);
  // pointer low bits pick the word, high bits the page; bit 0 dropped
  assign word_sel = pointer[`FSPC_WORD_BITS:1]; // see R19 and R14
  assign page_sel = pointer[`FSPC_WORD_BITS+`FSPC_PAGE_BITS:
    `FSPC_WORD_BITS+1]; // see R19
  assign op_start = do_store && ((cmd_reg == `FSPC_CMD_PGWR) ||
    (cmd_reg == `FSPC_CMD_PGER) || (cmd_reg == `FSPC_CMD_LOCK));
  assign fill_go = do_store && (cmd_reg == `FSPC_CMD_FILL);
  // reenable only reachable from armed, so never while busy
  assign reen_go = do_store && (cmd_reg == `FSPC_CMD_REEN); // see R7
  assign op_rww = (page_sel < `FSPC_NO_CONCURRENT_READ_SECTION_PAGE);
  assign readback = pointer[0] ? fuse_low_in : lock_bits_in; // see R10
  assign ctrl_view = {ie_reg, busy_reg, 1'b0, cmd_reg}; // see R17

  // ****************************************************************
  // command state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fspc_pkg::FSPC_IDLE: begin
        if (ctrl_wr && legal_cmd && !eeprom_write_busy) begin
          state_next = fspc_pkg::FSPC_ARMED; // see R24
        end
      end
      fspc_pkg::FSPC_ARMED: begin
        if (op_start && cmd_reg != `FSPC_CMD_LOCK) begin
          state_next = fspc_pkg::FSPC_BUSY;
        end else if (do_store || do_load || win_lapse) begin
          state_next = fspc_pkg::FSPC_IDLE; // see R15
        end
      end
      fspc_pkg::FSPC_BUSY: begin
        if (flash_done) begin
          state_next = fspc_pkg::FSPC_IDLE; // see R15
        end
      end
      default: state_next = fspc_pkg::FSPC_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= fspc_pkg::FSPC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // command bits: loaded on legal write from idle, frozen while busy
  always_ff @(posedge clock) begin
    if (srst) begin
      cmd_reg <= 5'h00;
      win_reg <= 3'h0;
      ld_win_reg <= 3'h0;
    end else if (state_reg == fspc_pkg::FSPC_IDLE && ctrl_wr &&
        legal_cmd && !eeprom_write_busy) begin
      cmd_reg <= reg_wdata[4:0]; // see R16 and R25
      win_reg <= `FSPC_STORE_WIN; // see R15
      ld_win_reg <= `FSPC_LOAD_WIN;
    end else if (state_next == fspc_pkg::FSPC_IDLE) begin
      cmd_reg <= 5'h00; // see R9, R11, R12, R15
      win_reg <= 3'h0;
      ld_win_reg <= 3'h0;
    end else if (armed) begin
      win_reg <= win_reg - 3'h1;
      ld_win_reg <= (ld_win_reg == 3'h0) ? 3'h0 : ld_win_reg - 3'h1;
    end
  end

  // interrupt enable is software owned, accepted even while busy
  always_ff @(posedge clock) begin
    if (srst) begin
      ie_reg <= 1'b0;
    end else if (ctrl_wr) begin
      ie_reg <= reg_wdata[`FSPC_BIT_IE];
    end
  end

  // busy: set wins since start and clears never share a cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      busy_reg <= 1'b0;
    end else if (op_start && cmd_reg != `FSPC_CMD_LOCK && op_rww) begin
      busy_reg <= 1'b1; // see R4
    end else if (reen_go || fill_go) begin
      busy_reg <= 1'b0; // see R5 and R6
    end
  end

  // ****************************************************************
  // page buffer, any word order
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst || reen_go ||
        (busy_op && flash_done && flash_op.write)) begin
      for (int i = 0; i < `FSPC_PAGE_WORDS; i++) begin
        flash_wdata[i] <= 16'h0000; // see R23 and R8
      end
    end else if (fill_go) begin
      flash_wdata[word_sel] <= {high_data_register,
        low_data_register}; // see R14 and R22
    end
  end

  // ****************************************************************
  // latched operation and core outputs
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      flash_op <= '0;
      flash_start <= 1'b0;
      cpu_halt <= 1'b0;
    end else begin
      flash_start <= op_start;
      if (op_start) begin
        flash_op.erase <= (cmd_reg == `FSPC_CMD_PGER); // see R12
        flash_op.write <= (cmd_reg == `FSPC_CMD_PGWR); // see R11
        flash_op.lock <= (cmd_reg == `FSPC_CMD_LOCK); // see R9
        flash_op.page <= page_sel; // see R18
        flash_op.lock_data <= low_data_register; // see R9
      end
      if (op_start && cmd_reg != `FSPC_CMD_LOCK && !op_rww) begin
        cpu_halt <= 1'b1; // see R13
      end else if (busy_op && flash_done) begin
        cpu_halt <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
      load_result <= 8'h00;
      load_result_valid <= 1'b0;
      ready_irq <= 1'b0;
      rww_blocked <= 1'b0;
      reset_vector <= `FSPC_APP_VEC;
    end else begin
      reg_rdata <= (reg_rd && reg_addr == `FSPC_CTRL_OFS) ?
        ctrl_view : 8'h00;
      load_result_valid <= do_load;
      if (do_load) begin
        load_result <= (pointer[1:0] == 2'b11) ? fuse_high_in :
          readback; // see R10
      end
      ready_irq <= ie_reg && global_irq_flag &&
        (state_next == fspc_pkg::FSPC_IDLE); // see R3
      rww_blocked <= busy_reg; // see R4
      // fuse is input only; nothing here can drive it
      reset_vector <= boot_reset_fuse ? `FSPC_APP_VEC :
        `FSPC_BOOT_VEC; // see R1 and R2
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  vector_select_a: assert property ( // see R1
    ##1 !$past(srst) |->
    reset_vector == ($past(boot_reset_fuse) ? `FSPC_APP_VEC :
    `FSPC_BOOT_VEC))
    else $error("reset vector mismatch");
  ready_irq_a: assert property ( // see R3
    ie_reg && global_irq_flag && state_next == fspc_pkg::FSPC_IDLE
    |=> ready_irq)
    else $error("ready irq missing");
  // quiet while an erase or write still runs
  irq_quiet_a: assert property ( // see R3
    busy_op && !flash_done
    |=> !ready_irq)
    else $error("ready irq during operation");
  rsvd_zero_a: assert property ( // see R17
    reg_rd
    |=> reg_rdata[5] == 1'b0)
    else $error("reserved bit not zero");

  // ****************************************************************
  // checks: command window
  // ****************************************************************
  window_lapse_a: assert property ( // see R15
    $rose(armed) |->
    ##[1:4] !armed)
    else $error("enable window too long");
  illegal_cmd_a: assert property ( // see R16
    state_reg == fspc_pkg::FSPC_IDLE && ctrl_wr && !legal_cmd
    |=> state_reg == fspc_pkg::FSPC_IDLE)
    else $error("illegal command took effect");
  frozen_cmd_a: assert property ( // see R25
    busy_op && !flash_done
    |=> $stable(cmd_reg))
    else $error("command changed while busy");
  // a reenable written mid-operation must leave the running command
  reen_refused_a: assert property ( // see R7
    busy_op && ctrl_wr && !flash_done
    |=> busy_op && cmd_reg != `FSPC_CMD_REEN)
    else $error("reenable accepted while busy");
  lock_clear_a: assert property ( // see R9
    op_start && cmd_reg == `FSPC_CMD_LOCK
    |=> state_reg == fspc_pkg::FSPC_IDLE && cmd_reg == 5'h00)
    else $error("lock command not cleared");
  eeprom_block_a: assert property ( // see R24
    eeprom_write_busy
    |-> !do_store && !do_load)
    else $error("store during eeprom write");

  // ****************************************************************
  // checks: section busy and cpu halt
  // ****************************************************************
  busy_set_a: assert property ( // see R4
    op_start && op_rww && cmd_reg == `FSPC_CMD_PGER
    |=> busy_reg && rww_blocked == 1'b0 ##1 rww_blocked)
    else $error("busy not set");
  busy_clear_a: assert property ( // see R5
    fill_go
    |=> !busy_reg)
    else $error("busy not cleared");
  rww_follow_a: assert property ( // see R4
    busy_reg
    |=> rww_blocked)
    else $error("section not blocked");
  halt_set_a: assert property ( // see R13
    op_start && cmd_reg != `FSPC_CMD_LOCK && !op_rww
    |=> cpu_halt && busy_op)
    else $error("cpu not halted");
  halt_hold_a: assert property ( // see R13
    cpu_halt && !(busy_op && flash_done)
    |=> cpu_halt)
    else $error("halt dropped early");

  // ****************************************************************
  // checks: page buffer, operation start and readback
  // ****************************************************************
  fill_store_a: assert property ( // see R14
    fill_go |=>
    flash_wdata[$past(word_sel)] ==
    {$past(high_data_register), $past(low_data_register)})
    else $error("buffer word not stored");
  reen_wipe_a: assert property ( // see R8
    reen_go |=>
    flash_wdata[0] == 16'h0000 && flash_wdata[31] == 16'h0000)
    else $error("buffer kept after reenable");
  write_wipe_a: assert property ( // see R23
    busy_op && flash_done && flash_op.write |=>
    flash_wdata[0] == 16'h0000 && flash_wdata[31] == 16'h0000)
    else $error("buffer kept after page write");
  addr_hold_a: assert property ( // see R18
    busy_op && !flash_done
    |=> $stable(flash_op))
    else $error("latched address changed");
  start_erase_a: assert property ( // see R12
    op_start && cmd_reg == `FSPC_CMD_PGER |=>
    flash_start && flash_op.erase && !flash_op.write)
    else $error("erase not started");
  start_write_a: assert property ( // see R11
    op_start && cmd_reg == `FSPC_CMD_PGWR |=>
    flash_start && flash_op.write && !flash_op.erase)
    else $error("page write not started");
  load_value_a: assert property ( // see R10
    do_load && !pointer[0] |=>
    load_result_valid && load_result == $past(lock_bits_in))
    else $error("lock bits not returned");

  // main scenarios the bench is expected to reach
  fill_c: cover property (fill_go);
  erase_rww_c: cover property (op_start && op_rww);
  halt_c: cover property ($rose(cpu_halt) ##[1:20] !cpu_halt);
  readback_c: cover property (do_load);
  lock_c: cover property (op_start && cmd_reg == `FSPC_CMD_LOCK);

endmodule // fspc_ctrl

/* fspc_core_model.sv */
// core model: issues store and load program instructions with operands
// assumes the bench calls exec from the block's clock domain
`timescale 1ns/1ps

module fspc_core_model (
  // clock
  input wire logic clock,
  // instruction side
  output logic store_program_instruction,
  output logic load_program_instruction,
  output logic [15:0] pointer,
  output logic [7:0] low_data_register,
  output logic [7:0] high_data_register
);
  // ****************
  // instruction issue
  // ****************
  initial begin
    store_program_instruction = 1'b0;
    load_program_instruction = 1'b0;
    pointer = 16'h0000;
    {high_data_register, low_data_register} = 16'h0000;
  end

  // operands are inverted once the strobe drops, so late sampling shows
  task automatic exec(input logic ld, input logic [15:0] p,
      input logic [15:0] d);
    @(posedge clock);
    store_program_instruction <= ~ld;
    load_program_instruction <= ld;
    pointer <= p;
    {high_data_register, low_data_register} <= d;
    @(posedge clock);
    store_program_instruction <= 1'b0;
    load_program_instruction <= 1'b0;
    pointer <= ~p;
    {high_data_register, low_data_register} <= ~d;
  endtask
endmodule // fspc_core_model

/* fspc_ctrl_test.sv */
// bench for the self-programming control block
// assumes the core model drives the instruction side; bench plays the array
`timescale 1ns/1ps
`include "fspc_regs.svh"

module fspc_ctrl_test;
  // ****************
  // signals
  // ****************
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic global_irq_flag = 1'b1;
  logic eeprom_write_busy = 1'b0;
  logic boot_reset_fuse = 1'b1;
  logic flash_done = 1'b0;
  logic [7:0] lock_bits_in = 8'hC3;
  logic [7:0] fuse_low_in = 8'h5A;
  logic [7:0] fuse_high_in = 8'hA5;
  logic store_program_instruction, load_program_instruction;
  logic [15:0] pointer;
  logic [7:0] low_data_register, high_data_register, reg_rdata, load_result;
  logic [11:0] reset_vector;
  logic load_result_valid, cpu_halt, rww_blocked, ready_irq, flash_start;
  fspc_pkg::fspc_op_t flash_op;
  logic [15:0] flash_wdata [`FSPC_PAGE_WORDS];
  logic [15:0] rb_ptr [3] = '{16'h0000, 16'h0001, 16'h0003};
  logic [7:0] rb_exp [3] = '{8'hC3, 8'h5A, 8'hA5};
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #25 clock = ~clock;

  fspc_ctrl fspc_ctrl_i (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .store_program_instruction,
    .load_program_instruction, .pointer, .low_data_register,
    .high_data_register, .global_irq_flag, .eeprom_write_busy,
    .boot_reset_fuse, .reset_vector, .load_result, .load_result_valid,
    .cpu_halt, .rww_blocked, .ready_irq, .lock_bits_in, .fuse_low_in,
    .fuse_high_in, .flash_done, .flash_op, .flash_start, .flash_wdata);
  fspc_core_model fspc_core_model_i (.clock, .store_program_instruction,
    .load_program_instruction, .pointer, .low_data_register,
    .high_data_register);

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= 4'h0;
    #1;
    chk(reg_rdata, e);
  endtask

  // waits for flash_start (ld=0) or load_result_valid (ld=1), bounded
  task automatic waitfor(input logic ld);
    int i;
    i = 0;
    // the pulse stands only one cycle: look just after the launching edge
    #1;
    while ((ld ? load_result_valid : flash_start) !== 1'b1 && i < 6) begin
      @(posedge clock);
      #1;
      i++;
    end
    chk(i < 6, 1'b1);
  endtask

  task automatic op(input logic [7:0] c, input logic [15:0] p);
    wr(c);
    fspc_core_model_i.exec(1'b0, p, 16'hFFFF);
    waitfor(1'b0);
  endtask

  task automatic done();
    @(posedge clock);
    flash_done <= 1'b1;
    @(posedge clock);
    flash_done <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ceiling well above the roughly 150 cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ****************
  // tests
  // ****************
  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    rdchk(4'h0, 8'h00);
    rdchk(4'h3, 8'h00);
    chk(reset_vector, 12'h000);
    @(posedge clock);
    boot_reset_fuse <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(reset_vector, 12'hC00);
    $display("reset test done");
    wr(8'h80);
    repeat (2) @(posedge clock);
    #1;
    chk(ready_irq, 1'b1);
    wr(8'h81);
    @(posedge clock);
    #1;
    chk(ready_irq, 1'b0);
    fspc_core_model_i.exec(1'b0, 16'h0007, 16'hBEEF);
    wr(8'h81);
    fspc_core_model_i.exec(1'b0, 16'h0002, 16'h1234);
    repeat (2) @(posedge clock);
    #1;
    chk(flash_wdata[3], 16'hBEEF);
    chk(flash_wdata[1], 16'h1234);
    chk(ready_irq, 1'b1);
    wr(8'h01);
    repeat (5) @(posedge clock);
    fspc_core_model_i.exec(1'b0, 16'h0004, 16'h5555);
    rdchk(4'h0, 8'h00);
    chk(flash_wdata[2], 16'h0000);
    wr(8'h07);
    rdchk(4'h0, 8'h00);
    wr(8'h13);
    rdchk(4'h0, 8'h00);
    $display("fill test done");
    op(8'h03, 16'h0140);
    chk(flash_op.erase, 1'b1);
    chk(flash_op.page, 7'h05);
    wr(8'h05);
    rdchk(4'h0, 8'h43);
    chk(rww_blocked, 1'b1);
    chk(cpu_halt, 1'b0);
    chk(flash_op.page, 7'h05);
    done();
    rdchk(4'h0, 8'h40);
    op(8'h05, 16'h0140);
    chk(flash_op.write, 1'b1);
    chk(flash_wdata[3], 16'hBEEF);
    wr(8'h11);
    rdchk(4'h0, 8'h45);
    done();
    chk(flash_wdata[3], 16'h0000);
    rdchk(4'h0, 8'h40);
    wr(8'h11);
    fspc_core_model_i.exec(1'b0, 16'h0000, 16'h0000);
    rdchk(4'h0, 8'h00);
    chk(rww_blocked, 1'b0);
    op(8'h03, 16'h0180);
    done();
    wr(8'h01);
    fspc_core_model_i.exec(1'b0, 16'h0000, 16'h0F0F);
    rdchk(4'h0, 8'h00);
    chk(flash_wdata[0], 16'h0F0F);
    wr(8'h11);
    fspc_core_model_i.exec(1'b0, 16'h0000, 16'h0000);
    rdchk(4'h0, 8'h00);
    chk(flash_wdata[0], 16'h0000);
    $display("section test done");
    op(8'h05, 16'h1800);
    @(posedge clock);
    #1;
    chk(cpu_halt, 1'b1);
    chk(rww_blocked, 1'b0);
    done();
    chk(cpu_halt, 1'b0);
    op(8'h09, 16'h0000);
    chk(flash_op.lock, 1'b1);
    chk(flash_op.lock_data, 8'hFF);
    rdchk(4'h0, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wr(8'h09);
      fspc_core_model_i.exec(1'b1, rb_ptr[k], 16'h0000);
      waitfor(1'b1);
      chk(load_result, rb_exp[k]);
    end
    @(posedge clock);
    eeprom_write_busy <= 1'b1;
    wr(8'h01);
    rdchk(4'h0, 8'h00);
    @(posedge clock);
    eeprom_write_busy <= 1'b0;
    $display("operation test done");
    wr(8'h01);
    fspc_core_model_i.exec(1'b0, 16'h0010, 16'h7777);
    @(posedge clock);
    #1;
    chk(flash_wdata[8], 16'h7777);
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    #1;
    chk(flash_wdata[8], 16'h0000);
    chk(reset_vector, 12'h000);
    @(posedge clock);
    #1;
    chk(reset_vector, 12'hC00);
    rdchk(4'h0, 8'h00);
    $display("midrun reset test done");
    give_verdict();
  end
endmodule // fspc_ctrl_test
